// ===== sim/eisa_slave_io_port_tb_top.sv
`timescale 1ns/1ps
module eisa_slave_io_port_tb_top;
   localparam logic [15:4] BASE = 12'h2A5;
   logic        core_clk, resetn, cmdValid, cmdReady, cmdWrite;
   logic [15:2] cmdAddr, rdAddr, wrAddr, sAddr;
   logic [3:0]  cmdLanesN, rdLanes, wrLanes, sLanes, intrEdge, irqReq;
   logic [31:0] cmdData, rspData, rdData, wrData, sData;
   logic        dmaBurst, busMemNotIo, busAddrEnable, rspValid;
   logic        devSelectedN, rdReq, wrValid;
   int          err_count, samples_checked, io_read_strobe_n, io_write_strobe_n;

   eisp_bus_if bus ();
   eisp_host_port i_eisp_host_port (.core_clk(core_clk), .resetn(resetn),
      .bus(bus), .cmdValid(cmdValid), .cmdReady(cmdReady),
      .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdLanesN(cmdLanesN),
      .cmdData(cmdData), .dmaBurst(dmaBurst), .busMemNotIo(busMemNotIo),
      .busAddrEnable(busAddrEnable), .rspValid(rspValid),
      .rspData(rspData), .intrEdge(intrEdge), .devSelectedN(devSelectedN));
   eisp_dev_port #(.DEV_BASE(BASE)) i_eisp_dev_port (.core_clk(core_clk),
      .resetn(resetn), .bus(bus), .rdReq(rdReq), .rdAddr(rdAddr),
      .rdLanes(rdLanes), .rdData(rdData), .wrValid(wrValid),
      .wrAddr(wrAddr), .wrLanes(wrLanes), .wrData(wrData), .irqReq(irqReq));
   eisp_bus_chk #(.DEV_BASE(BASE)) i_eisp_bus_chk (.core_clk(core_clk),
      .resetn(resetn), .addressStrobeN(bus.addressStrobeN),
      .ioAccessQualifier(bus.ioAccessQualifier),
      .ioReadStrobeN(bus.ioReadStrobeN), .ioWriteStrobeN(bus.ioWriteStrobeN),
      .byteLaneSelectsN(bus.byteLaneSelectsN),
      .wordAddressLines(bus.wordAddressLines), .devDataOeN(bus.devDataOeN),
      .localDeviceSelectN(bus.localDeviceSelectN));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wrap_up();
      if (err_count == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask

   // Pulses last one cycle, so each cycle is sampled once after its edge.
   task automatic do_cmd(input logic w, input logic [15:2] a,
                         input logic [3:0] ln, input logic [31:0] d);
      int n;
      n = 0;
      while (cmdReady !== 1'b1 && n < 80) begin
         tick();
         n++;
      end
      if (n == 80) begin
         chk("cmdReady", 1, cmdReady);
         wrap_up();
      end
      cmdValid = 1'b1;
      cmdWrite = w;
      cmdAddr = a;
      cmdLanesN = ln;
      cmdData = d;
      tick();
      cmdValid = 1'b0;
      io_read_strobe_n = 0;
      io_write_strobe_n = 0;
      repeat (30) begin
         if (rdReq === 1'b1) begin
            io_read_strobe_n++;
            sAddr = rdAddr;
            sLanes = rdLanes;
         end
         if (wrValid === 1'b1) begin
            io_write_strobe_n++;
            sAddr = wrAddr;
            sLanes = wrLanes;
            sData = wrData;
         end
         if (rspValid === 1'b1)
            sData = rspData;
         tick();
      end
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_lanes();
      logic [3:0]  pats [7];
      logic [3:0]  m;
      logic [31:0] e, ew, wd;
      pats = '{4'h0, 4'hC, 4'h3, 4'hE, 4'hD, 4'hB, 4'h7};
      for (int i = 0; i < 7; i++) begin
         m = ~pats[i];
         rdData = 32'hA1B2C3D4 + 32'(i);
         wd = 32'h5E6F7A8B - 32'(i);
         for (int k = 0; k < 4; k++) begin
            e[8*k +: 8] = m[k] ? rdData[8*k +: 8] : 8'hFF;
            ew[8*k +: 8] = m[k] ? wd[8*k +: 8] : 8'h00;
         end
         do_cmd(1'b0, {BASE, 2'(i)}, pats[i], 32'h0000_0000);
         chk("rdReq count", 1, io_read_strobe_n);
         chk("rdAddr", {BASE, 2'(i)}, sAddr);
         chk("rdLanes", m, sLanes);
         chk("rspData", e, sData);
         chk("devSelectedN", 0, devSelectedN);
         chk("halfword bit", 0, bus.halfwordAddressBit);
         do_cmd(1'b1, {BASE, 2'(i + 1)}, pats[i], wd);
         chk("wrValid count", 1, io_write_strobe_n);
         chk("wrAddr", {BASE, 2'(i + 1)}, sAddr);
         chk("wrLanes", m, sLanes);
         chk("wrData", ew, sData);
      end
   endtask

   task automatic t_refuse();
      for (int c = 0; c < 4; c++) begin
         busAddrEnable = (c == 0);
         busMemNotIo = (c == 1);
         for (int w = 0; w < 2; w++) begin
            do_cmd(w[0], (c == 2) ? 14'h0000 : {BASE, 2'b00},
                   (c == 3) ? 4'h5 : 4'h0, 32'h1234_5678);
            chk("refused rdReq", 0, io_read_strobe_n);
            chk("refused wrValid", 0, io_write_strobe_n);
            if (c < 3)
               chk("devSelectedN", 1, devSelectedN);
            if (w == 0 && c >= 2)
               chk("floating rspData", 32'hFFFF_FFFF, sData);
         end
      end
      busAddrEnable = 1'b0;
      busMemNotIo = 1'b0;
   endtask

   task automatic t_irq();
      int n;
      for (int k = 0; k < 4; k++) begin
         irqReq = 4'h1 << k;
         n = 0;
         repeat (8) begin
            tick();
            if (intrEdge === irqReq)
               n++;
         end
         chk("intrEdge rise", 1, n);
         chk("interruptOutputs", irqReq, bus.interruptOutputs);
         irqReq = 4'h0;
         n = 0;
         repeat (8) begin
            tick();
            if (intrEdge !== 4'h0)
               n++;
         end
         chk("intrEdge fall", 0, n);
      end
   endtask

   task automatic t_dma();
      int n;
      n = 0;
      dmaBurst = 1'b1;
      repeat (3) tick();
      chk("cmdReady in burst", 0, cmdReady);
      cmdValid = 1'b1;
      cmdWrite = 1'b0;
      cmdAddr = {BASE, 2'b00};
      cmdLanesN = 4'h0;
      repeat (12) begin
         tick();
         if (bus.ioReadStrobeN !== 1'b1 || bus.ioWriteStrobeN !== 1'b1)
            n++;
      end
      chk("strobes in burst", 0, n);
      cmdValid = 1'b0;
      tick();
      dmaBurst = 1'b0;
      do_cmd(1'b0, {BASE, 2'b01}, 4'h0, 32'h0000_0000);
      chk("rdReq after burst", 1, io_read_strobe_n);
   endtask

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      chk("watchdog", 0, 1);
      wrap_up();
   end

   initial begin
      resetn = 1'b0;
      cmdValid = 1'b0;
      cmdWrite = 1'b0;
      cmdAddr = 14'h0000;
      cmdLanesN = 4'hF;
      cmdData = 32'h0000_0000;
      dmaBurst = 1'b0;
      busMemNotIo = 1'b0;
      busAddrEnable = 1'b0;
      rdData = 32'h0000_0000;
      irqReq = 4'h0;
      err_count = 0;
      samples_checked = 0;
      repeat (16) @(posedge core_clk);
      #1;
      resetn = 1'b1;
      t_lanes();
      t_refuse();
      t_irq();
      t_dma();
      wrap_up();
   end
endmodule

// ===== sim/eisp_bus_chk.sv
`timescale 1ns/1ps
module eisp_bus_chk #(
   parameter logic [15:4] DEV_BASE = 12'h030
) (
   input wire logic        core_clk,
   input wire logic        resetn,
   input wire logic        addressStrobeN,
   input wire logic        ioAccessQualifier,
   input wire logic        ioReadStrobeN,
   input wire logic        ioWriteStrobeN,
   input wire logic [3:0]  byteLaneSelectsN,
   input wire logic [15:2] wordAddressLines,
   input wire logic [3:0]  devDataOeN,
   input wire logic        localDeviceSelectN
);
   logic [3:0] lanesReg;
   logic       hit;
   logic       lanesOk;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   // Lanes as the device must have captured them for the open access.
   always_ff @(posedge core_clk) begin
      if (!resetn)
         lanesReg <= 4'hF;
      else if (!addressStrobeN)
         lanesReg <= byteLaneSelectsN;
   end

   assign hit = !addressStrobeN && !ioAccessQualifier &&
                wordAddressLines[15:4] == DEV_BASE;
   assign lanesOk = lanesReg inside {4'h0, 4'hC, 4'h3, 4'hE, 4'hD, 4'hB,
                                     4'h7};

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   property p_sel_hit;
      hit [*4] |-> !localDeviceSelectN;
   endproperty
   a_sel_hit: assert property (p_sel_hit)
      else $error("select not asserted on a decode hit");
   property p_qual_off;
      (!addressStrobeN && ioAccessQualifier) [*4] |-> localDeviceSelectN;
   endproperty
   a_qual_off: assert property (p_qual_off)
      else $error("select asserted while qualifier high");
   property p_sel_held;
      hit [*4] ##1 addressStrobeN [*4] |-> !localDeviceSelectN;
   endproperty
   a_sel_held: assert property (p_sel_held)
      else $error("decode lost after address strobe rose");
   property p_drive_lanes;
      devDataOeN != 4'hF |-> devDataOeN == lanesReg && lanesOk;
   endproperty
   a_drive_lanes: assert property (p_drive_lanes)
      else $error("driven lanes differ from captured lanes");
   property p_drive_start;
      $fell(ioReadStrobeN) && !localDeviceSelectN && lanesOk
         |-> ##[2:6] devDataOeN != 4'hF;
   endproperty
   a_drive_start: assert property (p_drive_start)
      else $error("selected read not driven in time");
   property p_drive_stop;
      $rose(ioReadStrobeN) |-> ##[1:5] devDataOeN == 4'hF;
   endproperty
   a_drive_stop: assert property (p_drive_stop)
      else $error("data still driven after read strobe");
   property p_refuse;
      $fell(ioReadStrobeN) && localDeviceSelectN
         |-> (devDataOeN == 4'hF) [*8];
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("data driven on an unselected read");
   property p_addr_hold;
      !ioReadStrobeN || !ioWriteStrobeN
         |-> $stable(wordAddressLines) && $stable(byteLaneSelectsN);
   endproperty
   a_addr_hold: assert property (p_addr_hold)
      else $error("address moved during a command strobe");

   c_read: cover property ($fell(ioReadStrobeN) && !localDeviceSelectN);
   c_write: cover property ($fell(ioWriteStrobeN) && !localDeviceSelectN);
   c_refused: cover property ($fell(ioReadStrobeN) && localDeviceSelectN);
endmodule

// ===== src/eisp_bus_if.sv
`timescale 1ns/1ps
interface eisp_bus_if;
   logic        addressStrobeN;
   logic        ioAccessQualifier;
   logic        ioReadStrobeN;
   logic        ioWriteStrobeN;
   logic [3:0]  byteLaneSelectsN;
   logic [15:2] wordAddressLines;
   logic        halfwordAddressBit;
   logic [31:0] hostDataOut;
   logic [3:0]  hostDataOeN;
   logic [31:0] devDataOut;
   logic [3:0]  devDataOeN;
   logic [31:0] dataBus;
   logic [3:0]  interruptOutputs;
   logic        localDeviceSelectN;

   // A lane nobody drives floats high, as through a bus pull-up.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (!devDataOeN[i])
            dataBus[i*8 +: 8] = devDataOut[i*8 +: 8];
         else if (!hostDataOeN[i])
            dataBus[i*8 +: 8] = hostDataOut[i*8 +: 8];
         else
            dataBus[i*8 +: 8] = 8'hFF;
      end
   end

   modport dev (
      input  addressStrobeN, ioAccessQualifier, ioReadStrobeN,
      input  ioWriteStrobeN, byteLaneSelectsN, wordAddressLines,
      input  halfwordAddressBit, dataBus,
      output devDataOut, devDataOeN, interruptOutputs,
      output localDeviceSelectN
   );

   modport host (
      output addressStrobeN, ioAccessQualifier, ioReadStrobeN,
      output ioWriteStrobeN, byteLaneSelectsN, wordAddressLines,
      output halfwordAddressBit, hostDataOut, hostDataOeN,
      input  dataBus, interruptOutputs, localDeviceSelectN
   );
endinterface

// ===== src/eisp_dev_port.sv
`timescale 1ns/1ps
module eisp_dev_port #(
   parameter logic [15:4] DEV_BASE = 12'h030
) (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   eisp_bus_if.dev          bus,
   output      logic        rdReq,
   output      logic [15:2] rdAddr,
   output      logic [3:0]  rdLanes,
   input  wire logic [31:0] rdData,
   output      logic        wrValid,
   output      logic [15:2] wrAddr,
   output      logic [3:0]  wrLanes,
   output      logic [31:0] wrData,
   input  wire logic [3:0]  irqReq
);

   eisp_pkg::eisp_dev_t stateReg;
   eisp_pkg::eisp_dev_t stateNext;

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      logic        qualView;
      logic [15:2] addrView;
      logic        sel;
      logic [3:0]  mask;
      logic [31:0] laneBits;
      stateNext = stateReg;
      qualView  = 1'b1;
      addrView  = 14'h0000;
      sel       = 1'b0;
      mask      = 4'h0;
      laneBits  = 32'h0000_0000;

      // Every pin is asynchronous to core_clk; two stages before use.
      stateNext.strobeS1 = bus.addressStrobeN;
      stateNext.strobeS2 = stateReg.strobeS1;
      stateNext.qualS1   = bus.ioAccessQualifier;
      stateNext.qualS2   = stateReg.qualS1;
      stateNext.rdS1     = bus.ioReadStrobeN;
      stateNext.rdS2     = stateReg.rdS1;
      stateNext.rdQ      = stateReg.rdS2;
      stateNext.wrS1     = bus.ioWriteStrobeN;
      stateNext.wrS2     = stateReg.wrS1;
      stateNext.wrQ      = stateReg.wrS2;
      stateNext.addrS1   = bus.wordAddressLines;
      stateNext.addrS2   = stateReg.addrS1;
      stateNext.lanesS1  = bus.byteLaneSelectsN;
      stateNext.lanesS2  = stateReg.lanesS1;
      stateNext.dataS1   = bus.dataBus;
      stateNext.dataS2   = stateReg.dataS1;

      // -------------------------------------------------------------
      // Address phase latches
      // -------------------------------------------------------------
      // All three follow their pins while the strobe is low and keep
      // the last value once it rises, as a transparent latch would.
      if (!stateReg.strobeS2) begin
         stateNext.qualHeld  = stateReg.qualS2;
         stateNext.addrHeld  = stateReg.addrS2;
         stateNext.lanesHeld = stateReg.lanesS2;
      end
      qualView = stateReg.strobeS2 ? stateReg.qualHeld : stateReg.qualS2;
      addrView = stateReg.strobeS2 ? stateReg.addrHeld : stateReg.addrS2;

      // The halfword address bit is never read: lanes 2 and 3 alone
      // choose the upper halfword.
      sel  = (addrView[15:4] == DEV_BASE) && !qualView;
      mask = eisp_pkg::lane_mask(stateReg.lanesHeld);
      for (int i = 0; i < 4; i++)
         laneBits[i*8 +: 8] = {8{mask[i]}};

      stateNext.selectN = !sel;
      stateNext.intr    = irqReq;

      // -------------------------------------------------------------
      // Write: data taken at the strobe's trailing edge
      // -------------------------------------------------------------
      // Data and strobe share the same synchroniser depth, so the
      // data sampled with the rising strobe is the data at the edge.
      stateNext.wrValid = 1'b0;
      if (stateReg.wrS2 && !stateReg.wrQ && sel && mask != 4'h0) begin
         stateNext.wrValid = 1'b1;
         stateNext.wrAddr  = stateReg.addrHeld;
         stateNext.wrLanes = mask;
         stateNext.wrData  = stateReg.dataS2 & laneBits;
      end

      // -------------------------------------------------------------
      // Read: fetch on the leading edge, drive until release
      // -------------------------------------------------------------
      stateNext.rdReq = 1'b0;
      case (stateReg.rdState)
         eisp_pkg::RD_IDLE: begin
            if (!stateReg.rdS2 && stateReg.rdQ && sel
                && mask != 4'h0) begin
               stateNext.rdReq   = 1'b1;
               stateNext.rdAddr  = stateReg.addrHeld;
               stateNext.rdLanes = mask;
               stateNext.rdState = eisp_pkg::RD_FETCH;
            end
         end
         eisp_pkg::RD_FETCH: begin
            stateNext.dataOut = rdData;
            stateNext.dataOeN = ~stateReg.rdLanes;
            stateNext.rdState = eisp_pkg::RD_DRIVE;
         end
         eisp_pkg::RD_DRIVE: begin
            // A strobe released before the fetch ends still gets one
            // driven cycle; the bus has already moved on by then.
            if (stateReg.rdS2) begin
               stateNext.dataOeN = eisp_pkg::LANES_NONE;
               stateNext.rdState = eisp_pkg::RD_IDLE;
            end
         end
         default: begin
            stateNext.dataOeN = eisp_pkg::LANES_NONE;
            stateNext.rdState = eisp_pkg::RD_IDLE;
         end
      endcase

      if (!resetn)
         stateNext = eisp_pkg::DEV_RESET;
   end

   always_ff @(posedge core_clk) begin
      stateReg <= stateNext;
   end

   // ---------------------------------------------------------------
   // Outputs, all straight from the state register
   // ---------------------------------------------------------------
   assign bus.devDataOut         = stateReg.dataOut;
   assign bus.devDataOeN         = stateReg.dataOeN;
   assign bus.interruptOutputs   = stateReg.intr;
   assign bus.localDeviceSelectN = stateReg.selectN;
   assign rdReq                  = stateReg.rdReq;
   assign rdAddr                 = stateReg.rdAddr;
   assign rdLanes                = stateReg.rdLanes;
   assign wrValid                = stateReg.wrValid;
   assign wrAddr                 = stateReg.wrAddr;
   assign wrLanes                = stateReg.wrLanes;
   assign wrData                 = stateReg.wrData;

endmodule

// ===== src/eisp_host_port.sv
`timescale 1ns/1ps
module eisp_host_port (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   eisp_bus_if.host         bus,
   input  wire logic        cmdValid,
   output      logic        cmdReady,
   input  wire logic        cmdWrite,
   input  wire logic [15:2] cmdAddr,
   input  wire logic [3:0]  cmdLanesN,
   input  wire logic [31:0] cmdData,
   input  wire logic        dmaBurst,
   input  wire logic        busMemNotIo,
   input  wire logic        busAddrEnable,
   output      logic        rspValid,
   output      logic [31:0] rspData,
   output      logic [3:0]  intrEdge,
   output      logic        devSelectedN
);

   eisp_pkg::eisp_host_t stateReg;
   eisp_pkg::eisp_host_t stateNext;

   always_comb begin
      logic last;
      stateNext = stateReg;
      last      = (stateReg.cnt == 8'h00);

      stateNext.dataS1 = bus.dataBus;
      stateNext.dataS2 = stateReg.dataS1;
      stateNext.intrS1 = bus.interruptOutputs;
      stateNext.intrS2 = stateReg.intrS1;
      stateNext.intrQ  = stateReg.intrS2;
      stateNext.selS1  = bus.localDeviceSelectN;
      stateNext.selS2  = stateReg.selS1;

      // Only rising interrupt levels are reported.
      stateNext.intrEdge = stateReg.intrS2 & ~stateReg.intrQ;
      stateNext.qual     = busMemNotIo | busAddrEnable;
      stateNext.rspValid = 1'b0;
      stateNext.cnt      = last ? 8'h00 : stateReg.cnt - 8'h01;

      case (stateReg.state)
         eisp_pkg::H_IDLE: begin
            // A DMA burst holds off new I/O cycles entirely.
            if (cmdValid && stateReg.cmdReady && !dmaBurst) begin
               stateNext.state    = eisp_pkg::H_ADDR;
               stateNext.cmdReady = 1'b0;
               stateNext.strobeN  = 1'b0;
               stateNext.dirWrite = cmdWrite;
               stateNext.addr     = cmdAddr;
               stateNext.lanesN   = cmdLanesN;
               stateNext.dataOut  = cmdData;
               stateNext.cnt      = eisp_pkg::ADDR_CYC - 8'h01;
            end else begin
               stateNext.cmdReady = !dmaBurst;
            end
         end
         eisp_pkg::H_ADDR: begin
            if (last) begin
               stateNext.strobeN = 1'b1;
               stateNext.state   = eisp_pkg::H_GAP;
               stateNext.cnt     = eisp_pkg::GAP_CYC - 8'h01;
            end
         end
         eisp_pkg::H_GAP: begin
            // Address has been stable since the strobe went low.
            if (last && !dmaBurst) begin
               stateNext.state  = eisp_pkg::H_CMD;
               stateNext.readN  = stateReg.dirWrite;
               stateNext.writeN = !stateReg.dirWrite;
               if (stateReg.dirWrite)
                  stateNext.dataOeN = stateReg.lanesN;
               stateNext.cnt = eisp_pkg::CMD_CYC - 8'h01;
            end
         end
         eisp_pkg::H_CMD: begin
            if (last || dmaBurst) begin
               stateNext.readN  = 1'b1;
               stateNext.writeN = 1'b1;
               stateNext.state  = eisp_pkg::H_HOLD;
               stateNext.cnt    = eisp_pkg::GAP_CYC - 8'h01;
               if (!stateReg.dirWrite) begin
                  stateNext.rspValid = 1'b1;
                  stateNext.rspData  = stateReg.dataS2;
               end
            end
         end
         eisp_pkg::H_HOLD: begin
            // Write data outlives the strobe so the device samples it.
            if (last) begin
               stateNext.dataOeN = eisp_pkg::LANES_NONE;
               stateNext.state   = eisp_pkg::H_IDLE;
            end
         end
         default: begin
            stateNext.state = eisp_pkg::H_IDLE;
         end
      endcase

      if (!resetn)
         stateNext = eisp_pkg::HOST_RESET;
   end

   always_ff @(posedge core_clk) begin
      stateReg <= stateNext;
   end

   assign bus.addressStrobeN     = stateReg.strobeN;
   assign bus.ioAccessQualifier  = stateReg.qual;
   assign bus.ioReadStrobeN      = stateReg.readN;
   assign bus.ioWriteStrobeN     = stateReg.writeN;
   assign bus.byteLaneSelectsN   = stateReg.lanesN;
   assign bus.wordAddressLines   = stateReg.addr;
   assign bus.halfwordAddressBit = 1'b0;
   assign bus.hostDataOut        = stateReg.dataOut;
   assign bus.hostDataOeN        = stateReg.dataOeN;
   assign cmdReady               = stateReg.cmdReady;
   assign rspValid               = stateReg.rspValid;
   assign rspData                = stateReg.rspData;
   assign intrEdge               = stateReg.intrEdge;
   assign devSelectedN           = stateReg.selS2;

endmodule

// ===== src/eisp_pkg.sv
package eisp_pkg;

   // ---------------------------------------------------------------
   // Byte-lane select patterns, bit index = lane, active low
   // ---------------------------------------------------------------
   localparam logic [3:0] LANES_DWORD  = 4'h0;
   localparam logic [3:0] LANES_LOWORD = 4'hC;
   localparam logic [3:0] LANES_HIWORD = 4'h3;
   localparam logic [3:0] LANES_BYTE0  = 4'hE;
   localparam logic [3:0] LANES_BYTE1  = 4'hD;
   localparam logic [3:0] LANES_BYTE2  = 4'hB;
   localparam logic [3:0] LANES_BYTE3  = 4'h7;
   localparam logic [3:0] LANES_NONE   = 4'hF;

   // ---------------------------------------------------------------
   // Host cycle timing in core_clk cycles
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CYC = 8'h04;
   localparam logic [7:0] GAP_CYC  = 8'h04;
   localparam logic [7:0] CMD_CYC  = 8'h0A;

   // Returns the active-high lane mask, or zero for a pattern that
   // the port does not support.
   function automatic logic [3:0] lane_mask(input logic [3:0] selN);
      logic [3:0] m;
      m = 4'h0;
      case (selN)
         LANES_DWORD, LANES_LOWORD, LANES_HIWORD,
         LANES_BYTE0, LANES_BYTE1, LANES_BYTE2,
         LANES_BYTE3: m = ~selN;
         default:     m = 4'h0;
      endcase
      return m;
   endfunction

   // ---------------------------------------------------------------
   // Device end state
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      RD_IDLE  = 2'b00,
      RD_FETCH = 2'b01,
      RD_DRIVE = 2'b10
   } eisp_rd_state_t;

   typedef struct packed {
      logic           strobeS1, strobeS2;
      logic           qualS1, qualS2, qualHeld;
      logic           rdS1, rdS2, rdQ;
      logic           wrS1, wrS2, wrQ;
      logic [15:2]    addrS1, addrS2, addrHeld;
      logic [3:0]     lanesS1, lanesS2, lanesHeld;
      logic [31:0]    dataS1, dataS2;
      eisp_rd_state_t rdState;
      logic [31:0]    dataOut;
      logic [3:0]     dataOeN;
      logic [3:0]     intr;
      logic           selectN;
      logic           rdReq;
      logic [15:2]    rdAddr;
      logic [3:0]     rdLanes;
      logic           wrValid;
      logic [15:2]    wrAddr;
      logic [3:0]     wrLanes;
      logic [31:0]    wrData;
   } eisp_dev_t;

   localparam eisp_dev_t DEV_RESET = '{
      strobeS1: 1'b1, strobeS2: 1'b1,
      qualS1: 1'b1, qualS2: 1'b1, qualHeld: 1'b1,
      rdS1: 1'b1, rdS2: 1'b1, rdQ: 1'b1,
      wrS1: 1'b1, wrS2: 1'b1, wrQ: 1'b1,
      addrS1: 14'h0000, addrS2: 14'h0000, addrHeld: 14'h0000,
      lanesS1: 4'hF, lanesS2: 4'hF, lanesHeld: 4'hF,
      dataS1: 32'h0000_0000, dataS2: 32'h0000_0000,
      rdState: RD_IDLE,
      dataOut: 32'h0000_0000, dataOeN: 4'hF, intr: 4'h0,
      selectN: 1'b1, rdReq: 1'b0, rdAddr: 14'h0000, rdLanes: 4'h0,
      wrValid: 1'b0, wrAddr: 14'h0000, wrLanes: 4'h0,
      wrData: 32'h0000_0000};

   // ---------------------------------------------------------------
   // Host end state
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_ADDR = 3'b001,
      H_GAP  = 3'b010,
      H_CMD  = 3'b011,
      H_HOLD = 3'b100
   } eisp_host_state_t;

   typedef struct packed {
      eisp_host_state_t state;
      logic [7:0]       cnt;
      logic             dirWrite;
      logic             strobeN, readN, writeN, qual;
      logic [15:2]      addr;
      logic [3:0]       lanesN;
      logic [31:0]      dataOut;
      logic [3:0]       dataOeN;
      logic [31:0]      dataS1, dataS2;
      logic [3:0]       intrS1, intrS2, intrQ;
      logic             selS1, selS2;
      logic             cmdReady, rspValid;
      logic [31:0]      rspData;
      logic [3:0]       intrEdge;
   } eisp_host_t;

   localparam eisp_host_t HOST_RESET = '{
      state: H_IDLE, cnt: 8'h00, dirWrite: 1'b0,
      strobeN: 1'b1, readN: 1'b1, writeN: 1'b1, qual: 1'b1,
      addr: 14'h0000, lanesN: 4'hF, dataOut: 32'h0000_0000,
      dataOeN: 4'hF, dataS1: 32'h0000_0000, dataS2: 32'h0000_0000,
      intrS1: 4'h0, intrS2: 4'h0, intrQ: 4'h0,
      selS1: 1'b1, selS2: 1'b1, cmdReady: 1'b0, rspValid: 1'b0,
      rspData: 32'h0000_0000, intrEdge: 4'h0};

endpackage
